// ===== dv/ectl_far_end.sv
/*
 * far-end model: outside equipment driving the trigger and control pins
 * and sensing the two open-drain outputs through pull-ups.
 * assumes callers invoke its tasks just after a rising edge of aclk.
 */
`timescale 1ns/10ps
module ectl_far_end (
  // clock
  input wire logic aclk,
  // open-drain enables from the device
  input wire logic trig_out_oe,
  input wire logic status_output_pin_oe,
  // pins towards the device
  output logic ext_trigger_input,
  output logic control_input_one,
  output logic control_input_two,
  // resolved lines as outside equipment sees them
  output logic trig_line,
  output logic status_line
);
  ////////////////////////////////////////////////////////////////////////////////
  // pull-ups win unless the device sinks the line
  assign trig_line = trig_out_oe ? 1'b0 : 1'b1;
  assign status_line = status_output_pin_oe ? 1'b0 : 1'b1;

  // contacts open at power-up, so every input idles high
  initial begin
    ext_trigger_input = 1'b1;
    control_input_one = 1'b1;
    control_input_two = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // hold a trigger level; callers pick widths against the qualify counts
  task automatic trig(input logic l, input int n);
    ext_trigger_input <= l;
    repeat (n) @(posedge aclk);
  endtask

  // hold a control level; short holds are used on purpose to test rejection
  task automatic ctl(input logic p, input logic l, input int n);
    if (p) control_input_two <= l;
    else control_input_one <= l;
    repeat (n) @(posedge aclk);
  endtask
endmodule

// ===== dv/tb_external_control_terminal_logic.sv
/*
 * self-checking bench for ectl_top: axi4-lite master, pin scenarios.
 * assumes the far-end model owns the pins and the pull-up resolution.
 */
`timescale 1ns/10ps
module tb_external_control_terminal_logic;
  import ectl_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic ext_trigger_input, control_input_one, control_input_two, trig_line, status_line;
  logic trig_out_o, trig_out_oe, status_output_pin_o, status_output_pin_oe;
  logic meas_trigger, event_mark, meas_start, meas_stop, meas_abort, save_req, print_req;
  logic [6:0] pv;
  int mismatches = 0, comparisons = 0, run = 0, last = 0;
  int cnt[7] = '{default: 0};
  int base[7];

  always #2 aclk = ~aclk;

  // short counts keep the run brief; expectations below use them and the unshortened 500-cycle TRIG_LO_NOFILT_CYC and LEVEL_MIN_CYC
  ectl_top #(.TRIG_HI_NOFILT_CYCLES(20), .TRIG_FILT_CYCLES(30), .CTRL_HI_CYCLES(20),
    .CTRL_LO_CYCLES(30), .PULSE_OUT_CYCLES(16)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trigger_input,
    .control_input_one, .control_input_two, .trig_out_o, .trig_out_oe, .status_output_pin_o,
    .status_output_pin_oe, .meas_trigger, .event_mark, .meas_start, .meas_stop, .meas_abort,
    .save_req, .print_req);

  ectl_far_end u_far (.aclk, .trig_out_oe, .status_output_pin_oe, .ext_trigger_input,
    .control_input_one, .control_input_two, .trig_line, .status_line);

  ////////////////////////////////////////////////////////////////////////////////
  // pulse counters and the length of the last trigger output run
  assign pv = {print_req, save_req, meas_abort, meas_stop, meas_start, event_mark, meas_trigger};
  always @(posedge aclk) begin
    for (int i = 0; i < 7; i++) cnt[i] += (pv[i] === 1'b1) ? 1 : 0;
    if (trig_out_oe === 1'b1) run++;
    else begin
      if (run != 0) last = run;
      run = 0;
    end
  end

  task automatic ck(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // ready is combinational, so it is sampled mid-cycle where it is settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (tb !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (tr !== 1'b1);
  endtask

  function automatic int dl(input int i);
    return cnt[i] - base[i];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // low, high for hi, low, long high; n pulses on the chosen output
  task automatic trig_case(input logic [31:0] c, input int hi, input int n);
    int k;
    k = c[0] ? 1 : 0;
    wr(CFG_OFFS, c);
    base = cnt;
    u_far.trig(1'b0, 520);
    ck(dl(k) == ((c[1] && n > 0) ? 1 : 0), "wrong edge acted on");
    u_far.trig(1'b1, hi);
    u_far.trig(1'b0, 520);
    u_far.trig(1'b1, 60);
    ck(dl(k) == n && dl(1 - k) == 0, "trigger or event count");
  endtask

  task automatic ctl_case(input logic [31:0] c, input logic p, input int lo, input int i,
    input int n);
    wr(CFG_OFFS, c);
    base = cnt;
    u_far.ctl(p, 1'b0, lo);
    u_far.ctl(p, 1'b1, 40);
    ck(dl(i) == n, "control pulse count");
  endtask

  task automatic stat_case(input logic [31:0] cmd, input logic lvl);
    wr(CMD_OFFS, cmd);
    repeat (3) @(posedge aclk);
    ck(status_line === lvl, "status pin level");
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CFG_OFFS);
    ck(rdat === CFG_RESET, "cfg reset value");
    rd(8'h10);
    ck(rsp === RESP_SLVERR, "unmapped read");
    wr(STATUS_OFFS, 32'h0000_0000);
    ck(rsp === RESP_SLVERR, "status write");
    trig_case(32'h0000_1010, 60, 2);
    ck(last == 16, "pulse width");
    trig_case(32'h0000_1012, 60, 2);
    trig_case(32'h0000_1011, 60, 2);
    trig_case(32'h0000_1016, 25, 1);
    trig_case(32'h0000_1000, 60, 0);
    wr(HOLD_OFFS, 32'h0000_0000);
    wr(CFG_OFFS, 32'h0000_1018);
    u_far.trig(1'b0, 520);
    u_far.trig(1'b1, 600);
    ck(trig_line === 1'b0, "level output released early");
    wr(CMD_OFFS, 32'h0000_0001);
    repeat (4) @(posedge aclk);
    ck(trig_line === 1'b1, "level output held");
    wr(CFG_OFFS, 32'h0000_1010);
    last = 0;
    wr(CMD_OFFS, 32'h0000_0002);
    repeat (30) @(posedge aclk);
    ck(last == 16, "auto range output");
    ctl_case(32'h0000_1028, 1'b0, 50, 2, 1);
    ck(trig_line === 1'b0, "nocond");
    ctl_case(32'h0000_1000, 1'b1, 50, 3, 1);
    ctl_case(32'h0000_1000, 1'b0, 20, 2, 0);
    ctl_case(32'h0000_1200, 1'b0, 50, 3, 1);
    ctl_case(32'h0000_0300, 1'b1, 50, 2, 1);
    ctl_case(32'h0000_0300, 1'b0, 50, 4, 1);
    for (int f = 4; f < 6; f++) begin
      ctl_case(32'h0000_1000 | (f << 8), 1'b0, 50, f + 1, 1);
      ctl_case(32'h0000_1000 | (f << 8), 1'b0, 50, f + 1, 0);
    end
    wr(CFG_OFFS, 32'h0000_1000);
    stat_case(32'h0000_0008, 1'b0);
    stat_case(32'h0000_0010, 1'b1);
    ctl_case(32'h0002_1000, 1'b0, 50, 2, 1);
    stat_case(32'h0000_0004, 1'b0);
    wr(CFG_OFFS, 32'h0001_1000);
    stat_case(32'h0000_01a0, 1'b0);
    end_of_test;
  end

  // the scenarios need about 8000 cycles; more means a hang
  initial begin
    repeat (25000) @(posedge aclk);
    mismatches++;
    end_of_test;
  end
endmodule

// ===== shared/ectl_pkg.sv
/*
 * constants for the external control terminal block: register map,
 * field positions, reset values, pulse timing and function codes.
 * assumes a 250 MHz system clock and a 32-bit axi4-lite register bus.
 */
package ectl_pkg;

  // clock
  localparam int unsigned CLK_MHZ = 250;

  // timing figures as printed, in their own units
  localparam int unsigned TRIG_HI_NOFILT_US = 1000;
  localparam int unsigned TRIG_LO_NOFILT_NS = 2000;
  localparam int unsigned TRIG_FILT_US = 2500;
  localparam int unsigned CTRL_HI_MS = 20;
  localparam int unsigned CTRL_LO_MS = 30;
  localparam int unsigned PULSE_OUT_US = 2000;
  localparam int unsigned LEVEL_MIN_NS = 2000;

  // derived cycle counts
  localparam int unsigned TRIG_HI_NOFILT_CYC = TRIG_HI_NOFILT_US * CLK_MHZ;
  localparam int unsigned TRIG_LO_NOFILT_CYC = (TRIG_LO_NOFILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TRIG_FILT_CYC = TRIG_FILT_US * CLK_MHZ;
  localparam int unsigned CTRL_HI_CYC = CTRL_HI_MS * 1000 * CLK_MHZ;
  localparam int unsigned CTRL_LO_CYC = CTRL_LO_MS * 1000 * CLK_MHZ;
  localparam int unsigned PULSE_OUT_CYC = PULSE_OUT_US * CLK_MHZ;
  localparam int unsigned LEVEL_MIN_CYC = (LEVEL_MIN_NS * CLK_MHZ + 999) / 1000;

  // register byte offsets
  localparam logic [7:0] CFG_OFFS = 8'h00;
  localparam logic [7:0] CMD_OFFS = 8'h04;
  localparam logic [7:0] STATUS_OFFS = 8'h08;
  localparam logic [7:0] HOLD_OFFS = 8'h0c;

  // cfg field positions
  localparam int unsigned CFG_TRIG_EVENT_BIT = 0;
  localparam int unsigned CFG_TRIG_FALL_BIT = 1;
  localparam int unsigned CFG_FILT_BIT = 2;
  localparam int unsigned CFG_OUT_LEVEL_BIT = 3;
  localparam int unsigned CFG_EXT_EN_BIT = 4;
  localparam int unsigned CFG_NOCOND_BIT = 5;
  localparam int unsigned CFG_FN1_LSB = 8;
  localparam int unsigned CFG_FN2_LSB = 12;
  localparam int unsigned CFG_STAT_LSB = 16;

  // control input functions
  localparam logic [2:0] FN_START = 3'h0;
  localparam logic [2:0] FN_STOP = 3'h1;
  localparam logic [2:0] FN_STARTSTOP = 3'h2;
  localparam logic [2:0] FN_ABORT = 3'h3;
  localparam logic [2:0] FN_SAVE = 3'h4;
  localparam logic [2:0] FN_PRINT = 3'h5;

  // status output modes
  localparam logic [1:0] STAT_ERROR = 2'h0;
  localparam logic [1:0] STAT_BUSY = 2'h1;
  localparam logic [1:0] STAT_WAIT = 2'h2;

  // cmd bits (write one to pulse)
  localparam int unsigned CMD_RETR_END_BIT = 0;
  localparam int unsigned CMD_AUTORANGE_BIT = 1;
  localparam int unsigned CMD_ARM_BIT = 2;
  localparam int unsigned CMD_ERR_SET_BIT = 3;
  localparam int unsigned CMD_ERR_CLR_BIT = 4;
  localparam int unsigned CMD_BUSY_SET_BIT = 5;
  localparam int unsigned CMD_BUSY_CLR_BIT = 6;
  localparam int unsigned CMD_SAVE_DONE_BIT = 7;
  localparam int unsigned CMD_PRINT_DONE_BIT = 8;

  // reset values: start on input one, stop on input two
  localparam logic [31:0] CFG_RESET = 32'h0000_1000;
  localparam logic [31:0] HOLD_RESET = 32'h0000_0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== verilog/ectl_top.sv
/*
 * external control terminal logic: trigger input qualifier, trigger
 * output in pulse or level mode, two control inputs, status output.
 * assumes pins are asynchronous, open-drain outputs pulled up outside,
 * and software holds the acquisition core through axi4-lite registers.
 */
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
// How it works
// RULE_01: unfiltered trigger input needs 1 ms high and 2 us low from driver.
// RULE_02: filtered trigger input needs 2.5 ms high and low from driver.
// RULE_03: trigger mode: selected edge of trigger input raises measurement trigger.
// RULE_04: event mode: selected edge raises an event mark instead.
// RULE_05: software chooses rising or falling as the active edge.
// RULE_06: trigger output is open-drain, active low, idles released high.
// RULE_07: level mode holds output low until retrieval ends, at least 2 us.
// RULE_08: pulse mode holds output low for 2 ms, then releases.
// RULE_09: with no trigger condition, output asserts once measurement runs.
// RULE_10: auto ranging also asserts the trigger output.
// RULE_11: control inputs need 20 ms high and 30 ms low from driver.
// RULE_12: control inputs active low; open reads high, short reads low.
// RULE_13: start function begins measurement; stop ends it with post processing.
// RULE_14: start-stop function runs measurement while input is low.
// RULE_15: abort ends measurement and skips post processing.
// RULE_16: save and print requests are ignored while that operation runs.
// RULE_17: after reset input one is start, input two is stop.
// RULE_18: error mode drives status low while an error is reported.
// RULE_19: busy mode drives status low while requests cannot be accepted.
// RULE_20: waiting mode drives status low while armed for a trigger.
// RULE_21: for synchronisation use filter off and level output mode.
// RULE_22: daisy chain: all instruments enable external trigger mode.
// RULE_23: parallel: only slaves enable external trigger, fired by master.
// RULE_24: inputs are synchronised and width-qualified before use.
`timescale 1ns/10ps
module ectl_top
  import ectl_pkg::*;
#(
  parameter int unsigned TRIG_HI_NOFILT_CYCLES = TRIG_HI_NOFILT_CYC,
  parameter int unsigned TRIG_FILT_CYCLES = TRIG_FILT_CYC,
  parameter int unsigned CTRL_HI_CYCLES = CTRL_HI_CYC,
  parameter int unsigned CTRL_LO_CYCLES = CTRL_LO_CYC,
  parameter int unsigned PULSE_OUT_CYCLES = PULSE_OUT_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // terminal pins
  input wire logic ext_trigger_input,
  input wire logic control_input_one,
  input wire logic control_input_two,
  output logic trig_out_o,
  output logic trig_out_oe,
  output logic status_output_pin_o,
  output logic status_output_pin_oe,
  // pulses to the acquisition core
  output logic meas_trigger,
  output logic event_mark,
  output logic meas_start,
  output logic meas_stop,
  output logic meas_abort,
  output logic save_req,
  output logic print_req
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, one generate loop over the three inputs
  logic [2:0] pin_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  assign pin_raw = {control_input_two, control_input_one, ext_trigger_input};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    // first stage feeds only the second
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync1_q[i] <= 1'b1;
        sync2_q[i] <= 1'b1;
      end else begin
        sync1_q[i] <= pin_raw[i]; // RULE_24
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] cfg_q;
  logic [31:0] hold_q;
  logic [31:0] cmd_pulse;
  logic err_q;
  logic busy_q;
  logic armed_q;
  logic meas_q;
  logic saving_q;
  logic printing_q;

  ////////////////////////////////////////////////////////////////////////
  // trigger input qualifier: level accepted after the minimum width
  logic trig_lvl_q;
  logic [31:0] trig_cnt_q;
  logic [31:0] trig_need;
  logic trig_edge;
  // the filter only changes the width needed for each level
  always_comb begin
    if (cfg_q[CFG_FILT_BIT]) begin
      trig_need = TRIG_FILT_CYCLES; // RULE_02
    end else if (trig_lvl_q) begin
      trig_need = TRIG_LO_NOFILT_CYC; // RULE_01 RULE_21
    end else begin
      trig_need = TRIG_HI_NOFILT_CYCLES;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_lvl_q <= 1'b1;
      trig_cnt_q <= 32'h0000_0000;
    end else if (sync2_q[0] == trig_lvl_q) begin
      trig_cnt_q <= 32'h0000_0000;
    end else if (trig_cnt_q + 32'd1 >= trig_need) begin
      trig_lvl_q <= sync2_q[0]; // RULE_24
      trig_cnt_q <= 32'h0000_0000;
    end else begin
      trig_cnt_q <= trig_cnt_q + 32'd1;
    end
  end

  // edge seen when the qualified level flips to the selected polarity
  assign trig_edge = (trig_cnt_q + 32'd1 >= trig_need) && (sync2_q[0] != trig_lvl_q)
                     && (sync2_q[0] == !cfg_q[CFG_TRIG_FALL_BIT]); // RULE_05

  ////////////////////////////////////////////////////////////////////////
  // control input qualifiers, active low
  logic [1:0] ctl_low_q;
  logic [1:0] ctl_fall;
  logic [1:0] ctl_rise;
  logic [31:0] ctl_cnt_q [2];

  for (genvar c = 0; c < 2; c++) begin : g_ctl
    logic [31:0] need;
    assign need = ctl_low_q[c] ? CTRL_HI_CYCLES : CTRL_LO_CYCLES; // RULE_11
    assign ctl_fall[c] = !sync2_q[c+1] && !ctl_low_q[c] && (ctl_cnt_q[c] + 32'd1 >= need);
    assign ctl_rise[c] = sync2_q[c+1] && ctl_low_q[c] && (ctl_cnt_q[c] + 32'd1 >= need);
    // open pin pulls high and reads as inactive
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctl_low_q[c] <= 1'b0;
        ctl_cnt_q[c] <= 32'h0000_0000;
      end else if (sync2_q[c+1] != ctl_low_q[c]) begin
        ctl_cnt_q[c] <= 32'h0000_0000;
      end else if (ctl_fall[c] || ctl_rise[c]) begin
        ctl_low_q[c] <= !sync2_q[c+1]; // RULE_12
        ctl_cnt_q[c] <= 32'h0000_0000;
      end else begin
        ctl_cnt_q[c] <= ctl_cnt_q[c] + 32'd1;
      end
    end
  end

  // decode the two inputs' functions into request terms
  logic req_start;
  logic req_stop;
  logic req_abort;
  logic req_save;
  logic req_print;
  always_comb begin
    logic [2:0] fn;
    fn = 3'h0;
    req_start = 1'b0;
    req_stop = 1'b0;
    req_abort = 1'b0;
    req_save = 1'b0;
    req_print = 1'b0;
    for (int c = 0; c < 2; c++) begin
      fn = cfg_q[CFG_FN1_LSB + 4*c +: 3];
      case (fn)
        FN_START: req_start = req_start | ctl_fall[c]; // RULE_13
        FN_STOP: req_stop = req_stop | ctl_fall[c];
        FN_STARTSTOP: begin
          req_start = req_start | ctl_fall[c]; // RULE_14
          req_stop = req_stop | ctl_rise[c];
        end
        FN_ABORT: req_abort = req_abort | ctl_fall[c]; // RULE_15
        FN_SAVE: req_save = req_save | ctl_fall[c];
        FN_PRINT: req_print = req_print | ctl_fall[c];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // measurement state and request pulses; busy refuses starts
  logic start_ok;
  assign start_ok = req_start && !busy_q && !meas_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_q <= 1'b0;
      meas_start <= 1'b0;
      meas_stop <= 1'b0;
      meas_abort <= 1'b0;
      save_req <= 1'b0;
      print_req <= 1'b0;
      saving_q <= 1'b0;
      printing_q <= 1'b0;
    end else begin
      meas_start <= start_ok;
      meas_stop <= req_stop && meas_q && !req_abort;
      meas_abort <= req_abort && meas_q; // RULE_15
      if (req_abort || req_stop) begin
        meas_q <= 1'b0;
      end else if (start_ok) begin
        meas_q <= 1'b1;
      end
      // a running save or print swallows a new request of its own kind
      save_req <= req_save && !saving_q && !busy_q; // RULE_16
      print_req <= req_print && !printing_q && !busy_q;
      if (req_save && !saving_q && !busy_q) begin
        saving_q <= 1'b1;
      end else if (cmd_pulse[CMD_SAVE_DONE_BIT]) begin
        saving_q <= 1'b0;
      end
      if (req_print && !printing_q && !busy_q) begin
        printing_q <= 1'b1;
      end else if (cmd_pulse[CMD_PRINT_DONE_BIT]) begin
        printing_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger and event pulses from the qualified edge
  logic trig_fire;
  assign trig_fire = trig_edge && cfg_q[CFG_EXT_EN_BIT] && !cfg_q[CFG_TRIG_EVENT_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_trigger <= 1'b0;
      event_mark <= 1'b0;
    end else begin
      meas_trigger <= trig_fire; // RULE_03 RULE_22 RULE_23
      event_mark <= trig_edge && cfg_q[CFG_TRIG_EVENT_BIT]; // RULE_04
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger output machine
  typedef enum logic [2:0] {
    ECTL_IDLE = 3'b001,
    ECTL_PULSE = 3'b010,
    ECTL_LEVEL = 3'b100
  } ectl_out_type;
  ectl_out_type out_q;
  logic [31:0] out_cnt_q;
  logic out_fire;
  logic nocond_q;
  // no-condition measuring and auto range also fire the output
  assign out_fire = trig_fire || (cfg_q[CFG_NOCOND_BIT] && start_ok) // RULE_09
                    || cmd_pulse[CMD_AUTORANGE_BIT]; // RULE_10

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= ECTL_IDLE;
      out_cnt_q <= 32'h0000_0000;
      nocond_q <= 1'b0;
    end else begin
      nocond_q <= 1'b0;
      case (out_q)
        ECTL_IDLE: begin
          out_cnt_q <= 32'h0000_0000;
          if (out_fire) begin
            out_q <= cfg_q[CFG_OUT_LEVEL_BIT] ? ECTL_LEVEL : ECTL_PULSE;
          end
        end
        ECTL_PULSE: begin
          out_cnt_q <= out_cnt_q + 32'd1;
          if (out_cnt_q + 32'd1 >= PULSE_OUT_CYCLES) begin
            out_q <= ECTL_IDLE; // RULE_08
          end
        end
        ECTL_LEVEL: begin
          // hold for the larger of the software figure and the 2 us floor
          if (out_cnt_q != 32'hffff_ffff) begin
            out_cnt_q <= out_cnt_q + 32'd1;
          end
          nocond_q <= cmd_pulse[CMD_RETR_END_BIT] || nocond_q;
          if ((cmd_pulse[CMD_RETR_END_BIT] || nocond_q) && out_cnt_q + 32'd1 >= LEVEL_MIN_CYC
              && out_cnt_q + 32'd1 >= hold_q) begin
            out_q <= ECTL_IDLE; // RULE_07
          end
        end
        default: out_q <= ECTL_IDLE;
      endcase
    end
  end

  // open drain: drive low only, output value stays zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_out_o <= 1'b0;
      trig_out_oe <= 1'b0;
    end else begin
      trig_out_o <= 1'b0;
      trig_out_oe <= out_fire || (out_q != ECTL_IDLE && !(out_q == ECTL_PULSE
                     && out_cnt_q + 32'd1 >= PULSE_OUT_CYCLES)); // RULE_06
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status output and soft status flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= 1'b0;
      busy_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      if (cmd_pulse[CMD_ERR_SET_BIT]) err_q <= 1'b1;
      else if (cmd_pulse[CMD_ERR_CLR_BIT]) err_q <= 1'b0;
      if (cmd_pulse[CMD_BUSY_SET_BIT]) busy_q <= 1'b1;
      else if (cmd_pulse[CMD_BUSY_CLR_BIT]) busy_q <= 1'b0;
      // armed from arm command until trigger or measurement end
      if (cmd_pulse[CMD_ARM_BIT]) armed_q <= 1'b1;
      else if (trig_fire || !meas_q) armed_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_output_pin_o <= 1'b0;
      status_output_pin_oe <= 1'b0;
    end else begin
      status_output_pin_o <= 1'b0;
      case (cfg_q[CFG_STAT_LSB +: 2])
        STAT_ERROR: status_output_pin_oe <= err_q; // RULE_18
        STAT_BUSY: status_output_pin_oe <= busy_q || saving_q || printing_q; // RULE_19
        STAT_WAIT: status_output_pin_oe <= armed_q; // RULE_20
        default: status_output_pin_oe <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data in either order
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic do_write;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      cfg_q <= CFG_RESET; // RULE_17
      hold_q <= HOLD_RESET;
      cmd_pulse <= 32'h0000_0000;
    end else begin
      cmd_pulse <= 32'h0000_0000;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wd_q <= s_axi_wdata;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        case (aw_q)
          CFG_OFFS: cfg_q <= wd_q;
          CMD_OFFS: cmd_pulse <= wd_q;
          HOLD_OFFS: hold_q <= wd_q;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read path, one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        CFG_OFFS: s_axi_rdata <= cfg_q;
        HOLD_OFFS: s_axi_rdata <= hold_q;
        STATUS_OFFS: s_axi_rdata <= {22'h00_0000, ctl_low_q, trig_lvl_q, printing_q,
                                     saving_q, armed_q, busy_q, err_q, meas_q,
                                     out_q != ECTL_IDLE};
        CMD_OFFS: s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_pulse_low;
    trig_out_oe [*8];
  endsequence

  property p_pulse_len;
    @(posedge aclk) disable iff (!aresetn)
      (out_q == ECTL_IDLE && out_fire && !cfg_q[CFG_OUT_LEVEL_BIT]) |=> s_pulse_low;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse too short"); // RULE_08

  property p_level_floor;
    @(posedge aclk) disable iff (!aresetn)
      (out_q == ECTL_LEVEL && out_cnt_q + 32'd1 < LEVEL_MIN_CYC) |=> trig_out_oe;
  endproperty
  a_level_floor: assert property (p_level_floor) else $error("level released early"); // RULE_07

  property p_od;
    @(posedge aclk) disable iff (!aresetn) trig_out_o == 1'b0 && status_output_pin_o == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("open drain drives high"); // RULE_06

  property p_trig;
    @(posedge aclk) disable iff (!aresetn) trig_fire |=> meas_trigger && !event_mark;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger missed"); // RULE_03

  property p_event;
    @(posedge aclk) disable iff (!aresetn)
      (trig_edge && cfg_q[CFG_TRIG_EVENT_BIT]) |=> event_mark && !meas_trigger;
  endproperty
  a_event: assert property (p_event) else $error("event missed"); // RULE_04

  property p_abort;
    @(posedge aclk) disable iff (!aresetn) meas_abort |-> !meas_stop && !meas_q;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ran post processing"); // RULE_15

  property p_save_busy;
    @(posedge aclk) disable iff (!aresetn) saving_q |=> !save_req;
  endproperty
  a_save_busy: assert property (p_save_busy) else $error("save while saving"); // RULE_16

  property p_err_out;
    @(posedge aclk) disable iff (!aresetn)
      (cfg_q[CFG_STAT_LSB +: 2] == STAT_ERROR && $stable(cfg_q))
        |=> status_output_pin_oe == $past(err_q);
  endproperty
  a_err_out: assert property (p_err_out) else $error("status not following error"); // RULE_18

endmodule
